/* rtl/bst_pkg.sv */
// package: constants for the boundary-scan test port
package bst_pkg;
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BC_W = 98;
    localparam int TMS_RESET_EDGES = 5;

    localparam logic [2:0] IR_EXTEST = 3'h0;
    localparam logic [2:0] IR_SAMPLE = 3'h4;
    localparam logic [2:0] IR_IDCODE = 3'h6;
    localparam logic [2:0] IR_BYPASS = 3'h7;
    // captured into the instruction latch in capture-ir, low two bits fixed
    localparam logic [2:0] IR_CAPTURE = 3'h1;

    localparam logic [3:0] ID_REV = 4'h1;
    localparam logic [15:0] ID_PART = 16'h1234;
    localparam logic [10:0] ID_PRODUCER = 11'h055;
    localparam logic ID_LSB = 1'b1;

    typedef enum logic [15:0] {
        BST_RESET = 16'h0001,
        BST_IDLE = 16'h0002,
        BST_SEL_DR = 16'h0004,
        BST_CAP_DR = 16'h0008,
        BST_SH_DR = 16'h0010,
        BST_EX1_DR = 16'h0020,
        BST_PAU_DR = 16'h0040,
        BST_EX2_DR = 16'h0080,
        BST_UPD_DR = 16'h0100,
        BST_SEL_IR = 16'h0200,
        BST_CAP_IR = 16'h0400,
        BST_SH_IR = 16'h0800,
        BST_EX1_IR = 16'h1000,
        BST_PAU_IR = 16'h2000,
        BST_EX2_IR = 16'h4000,
        BST_UPD_IR = 16'h8000
    } bst_state_e;
endpackage

/* rtl/bst_test_port.sv */
// module: boundary-scan test access port with controller and scan chains
`timescale 1ns/1ns
// Operation
// - tester steers via tms and tck, data in on tdi, out on tdo
// - three-bit instruction latch, shifted lsb first, decoded to pick chain
// - extest: boundary chain selected, capture samples input pins, shift outputs them
// - extest: output pins driven from boundary pattern after update
// - sample/preload: boundary chain selected, normal pin path, capture reads input pins only
// - idcode: identification chain selected and shifted out
// - bypass: tdi to tdo with one tck delay
// - identification chain 32 bits: bit0 one, producer, part, revision fields
// - identification chain shifted out lsb first
// - single-bit passthrough chain is one bit between tdi and tdo
// - 98-bit boundary chain applies and reads all digital pins
// - sixteen-state controller, transitions on tms at rising tck
// - five tck edges with tms high reach test-logic-reset, also at power-up
// - test-logic-reset loads idcode and selects normal operation
// - boundary latched outputs update on falling tck in update-dr only
module bst_test_port (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe_n,
    input wire logic [bst_pkg::BC_W-1:0] pin_capture,
    input wire logic [bst_pkg::BC_W-1:0] core_out,
    output logic [bst_pkg::BC_W-1:0] pin_drive,
    output logic test_mode,
    output logic [2:0] active_instr
);
    // ==========================================================
    // link domain: controller
    bst_pkg::bst_state_e st_q;
    bst_pkg::bst_state_e st_d;

    always_comb begin
        st_d = st_q;
        case (st_q)
            bst_pkg::BST_RESET: st_d = tms ? bst_pkg::BST_RESET : bst_pkg::BST_IDLE;
            bst_pkg::BST_IDLE: st_d = tms ? bst_pkg::BST_SEL_DR : bst_pkg::BST_IDLE;
            bst_pkg::BST_SEL_DR: st_d = tms ? bst_pkg::BST_SEL_IR : bst_pkg::BST_CAP_DR;
            bst_pkg::BST_CAP_DR: st_d = tms ? bst_pkg::BST_EX1_DR : bst_pkg::BST_SH_DR;
            bst_pkg::BST_SH_DR: st_d = tms ? bst_pkg::BST_EX1_DR : bst_pkg::BST_SH_DR;
            bst_pkg::BST_EX1_DR: st_d = tms ? bst_pkg::BST_UPD_DR : bst_pkg::BST_PAU_DR;
            bst_pkg::BST_PAU_DR: st_d = tms ? bst_pkg::BST_EX2_DR : bst_pkg::BST_PAU_DR;
            bst_pkg::BST_EX2_DR: st_d = tms ? bst_pkg::BST_UPD_DR : bst_pkg::BST_SH_DR;
            bst_pkg::BST_UPD_DR: st_d = tms ? bst_pkg::BST_SEL_DR : bst_pkg::BST_IDLE;
            bst_pkg::BST_SEL_IR: st_d = tms ? bst_pkg::BST_RESET : bst_pkg::BST_CAP_IR;
            bst_pkg::BST_CAP_IR: st_d = tms ? bst_pkg::BST_EX1_IR : bst_pkg::BST_SH_IR;
            bst_pkg::BST_SH_IR: st_d = tms ? bst_pkg::BST_EX1_IR : bst_pkg::BST_SH_IR;
            bst_pkg::BST_EX1_IR: st_d = tms ? bst_pkg::BST_UPD_IR : bst_pkg::BST_PAU_IR;
            bst_pkg::BST_PAU_IR: st_d = tms ? bst_pkg::BST_EX2_IR : bst_pkg::BST_PAU_IR;
            bst_pkg::BST_EX2_IR: st_d = tms ? bst_pkg::BST_UPD_IR : bst_pkg::BST_SH_IR;
            bst_pkg::BST_UPD_IR: st_d = tms ? bst_pkg::BST_SEL_DR : bst_pkg::BST_IDLE;
            default: st_d = bst_pkg::BST_RESET;
        endcase
    end

    // rst_n stands in for power-up; tck may stop between scans
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= bst_pkg::BST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // instruction latch
    logic [bst_pkg::IR_W-1:0] ir_sh_q;
    logic [bst_pkg::IR_W-1:0] instr_q;

    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            ir_sh_q <= bst_pkg::IR_CAPTURE;
        end else if (st_q == bst_pkg::BST_CAP_IR) begin
            ir_sh_q <= bst_pkg::IR_CAPTURE;
        end else if (st_q == bst_pkg::BST_SH_IR) begin
            ir_sh_q <= {tdi, ir_sh_q[bst_pkg::IR_W-1:1]};
        end
    end

    // latched on falling tck so the new code is stable before next rising edge
    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            instr_q <= bst_pkg::IR_IDCODE;
        end else if (st_q == bst_pkg::BST_RESET) begin
            instr_q <= bst_pkg::IR_IDCODE;
        end else if (st_q == bst_pkg::BST_UPD_IR) begin
            instr_q <= ir_sh_q;
        end
    end

    // ==========================================================
    // decode
    // shared by both domains so they never disagree on what extest is
    function automatic logic bst_code_is_extest(input logic [bst_pkg::IR_W-1:0] code);
        return code == bst_pkg::IR_EXTEST;
    endfunction

    wire sel_bc = bst_code_is_extest(instr_q) || (instr_q == bst_pkg::IR_SAMPLE);
    wire sel_id = (instr_q == bst_pkg::IR_IDCODE);
    // any other code, documented or not, picks the passthrough
    wire sel_bp = !sel_bc && !sel_id;
    wire cap_dr = (st_q == bst_pkg::BST_CAP_DR);
    wire sh_dr = (st_q == bst_pkg::BST_SH_DR);
    wire [bst_pkg::ID_W-1:0] id_value = {bst_pkg::ID_REV, bst_pkg::ID_PART,
        bst_pkg::ID_PRODUCER, bst_pkg::ID_LSB};

    // ==========================================================
    // data chains
    logic [bst_pkg::BC_W-1:0] bc_sh_q;
    logic [bst_pkg::BC_W-1:0] bc_upd_q;
    logic [bst_pkg::ID_W-1:0] id_sh_q;
    logic bp_q;

    // pins are asynchronous to tck; tck stops between scans, so the two edges
    // of select-dr and capture-dr entry are what settle a pin change
    logic [bst_pkg::BC_W-1:0] pin_s1_q;
    logic [bst_pkg::BC_W-1:0] pin_s2_q;

    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= '0;
        end else begin
            pin_s1_q <= pin_capture;
        end
    end

    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            pin_s2_q <= '0;
        end else begin
            pin_s2_q <= pin_s1_q;
        end
    end

    // extest and sample both read the same pin word; core_out itself is never captured
    wire [bst_pkg::BC_W-1:0] bc_cap = pin_s2_q;

    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            bc_sh_q <= '0;
        end else if (sel_bc && cap_dr) begin
            bc_sh_q <= bc_cap;
        end else if (sel_bc && sh_dr) begin
            bc_sh_q <= {tdi, bc_sh_q[bst_pkg::BC_W-1:1]};
        end
    end

    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            bc_upd_q <= '0;
        end else if (sel_bc && st_q == bst_pkg::BST_UPD_DR) begin
            bc_upd_q <= bc_sh_q;
        end
    end

    // toggles with every boundary update, telling the core a new word stands
    logic upd_tgl_q;

    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            upd_tgl_q <= 1'b0;
        end else if (sel_bc && st_q == bst_pkg::BST_UPD_DR) begin
            upd_tgl_q <= !upd_tgl_q;
        end
    end

    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            id_sh_q <= '0;
        end else if (sel_id && cap_dr) begin
            id_sh_q <= id_value;
        end else if (sel_id && sh_dr) begin
            id_sh_q <= {tdi, id_sh_q[bst_pkg::ID_W-1:1]};
        end
    end

    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            bp_q <= 1'b0;
        end else if (sel_bp && cap_dr) begin
            bp_q <= 1'b0;
        end else if (sel_bp && sh_dr) begin
            bp_q <= tdi;
        end
    end

    // ==========================================================
    // serial output, changes on falling tck per usual practice
    wire sh_ir = (st_q == bst_pkg::BST_SH_IR);
    wire dr_bit = sel_bc ? bc_sh_q[0] : (sel_id ? id_sh_q[0] : bp_q);
    wire tdo_d = sh_ir ? ir_sh_q[0] : dr_bit;

    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            tdo <= 1'b0;
        end else begin
            tdo <= tdo_d;
        end
    end

    // enable follows the shift states, so tdo is released outside scans
    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            tdo_oe_n <= 1'b1;
        end else begin
            tdo_oe_n <= !(sh_ir || sh_dr);
        end
    end

    // ==========================================================
    // core domain: reset release
    // rst_n lets go at any moment; core registers leave reset on a clean
    // core_clk edge two cycles later, so none of them sees a runt release
    logic core_rst_s1_q;
    logic core_rst_s2_q;
    wire core_rst_n = core_rst_s2_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_rst_s1_q <= 1'b0;
        end else begin
            core_rst_s1_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_rst_s2_q <= 1'b0;
        end else begin
            core_rst_s2_q <= core_rst_s1_q;
        end
    end

    // ==========================================================
    // core domain: boundary word handshake
    // a bare two-flop copy of a 98-bit word can land torn, half old and half new;
    // the word is taken only after its update toggle has crossed two flops,
    // by which time every bit has stood still for at least two core cycles
    logic tgl_s1_q;
    logic tgl_s2_q;
    logic tgl_s3_q;
    logic [bst_pkg::BC_W-1:0] upd_core_q;

    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            tgl_s1_q <= 1'b0;
        end else begin
            tgl_s1_q <= upd_tgl_q;
        end
    end

    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            tgl_s2_q <= 1'b0;
        end else begin
            tgl_s2_q <= tgl_s1_q;
        end
    end

    // third stage only remembers the previous toggle for edge detection
    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            tgl_s3_q <= 1'b0;
        end else begin
            tgl_s3_q <= tgl_s2_q;
        end
    end

    // limitation: a second update must not follow within three core cycles,
    // which a full 98-bit scan never does at any usable tck
    wire tgl_edge = tgl_s2_q ^ tgl_s3_q;

    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            upd_core_q <= '0;
        end else if (tgl_edge) begin
            upd_core_q <= bc_upd_q;
        end
    end

    // ==========================================================
    // core domain: instruction crossing
    // three bits may still arrive skewed; a code is accepted only when two
    // consecutive synchronised samples agree, so a torn code never reaches the pins
    logic [bst_pkg::IR_W-1:0] instr_s1_q;
    logic [bst_pkg::IR_W-1:0] instr_s2_q;
    logic [bst_pkg::IR_W-1:0] instr_ok_q;

    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            instr_s1_q <= bst_pkg::IR_IDCODE;
        end else begin
            instr_s1_q <= instr_q;
        end
    end

    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            instr_s2_q <= bst_pkg::IR_IDCODE;
        end else begin
            instr_s2_q <= instr_s1_q;
        end
    end

    wire instr_steady = (instr_s1_q == instr_s2_q);

    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            instr_ok_q <= bst_pkg::IR_IDCODE;
        end else if (instr_steady) begin
            instr_ok_q <= instr_s2_q;
        end
    end

    // ==========================================================
    // core domain: pin mux and status
    // instruction only changes in update-ir or test-logic-reset, so the mux settles well before pins care
    wire core_extest = bst_code_is_extest(instr_ok_q);
    wire [bst_pkg::BC_W-1:0] drive_d = core_extest ? upd_core_q : core_out;

    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            pin_drive <= '0;
        end else begin
            pin_drive <= drive_d;
        end
    end

    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            test_mode <= 1'b0;
        end else begin
            test_mode <= core_extest;
        end
    end

    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            active_instr <= bst_pkg::IR_IDCODE;
        end else begin
            active_instr <= instr_ok_q;
        end
    end
endmodule

/* tb/bst_test_port_monitor.sv */
// checker: port properties of the boundary-scan test port
`timescale 1ns/1ns
module bst_test_port_monitor (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdo_oe_n,
    input wire logic [bst_pkg::BC_W-1:0] core_out,
    input wire logic [bst_pkg::BC_W-1:0] pin_drive,
    input wire logic test_mode,
    input wire logic [2:0] active_instr
);
    // ========
    // link side
    sequence tms_held;
        tms [*5];
    endsequence
    oe_reset_a: assert property (@(posedge tck) disable iff (!rst_n)
        tms_held |=> tdo_oe_n) else $error("tdo enabled after tms reset");
    oe_enter_a: assert property (@(posedge tck) disable iff (!rst_n)
        $fell(tdo_oe_n) |-> !$past(tms)) else $error("shift entered with tms high");
    oe_leave_a: assert property (@(posedge tck) disable iff (!rst_n)
        $rose(tdo_oe_n) |-> $past(tms)) else $error("shift left with tms low");
    oe_hold_a: assert property (@(posedge tck) disable iff (!rst_n)
        !tdo_oe_n && !tms |=> !tdo_oe_n) else $error("shift left early");
    // ========
    // core side
    mode_match_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        test_mode == (active_instr == bst_pkg::IR_EXTEST)) else $error("test mode mismatch");
    mode_rise_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(test_mode) |-> $past(active_instr) != bst_pkg::IR_EXTEST) else $error("test mode rose alone");
    normal_path_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !test_mode && !$past(test_mode) && $past(rst_n) |-> pin_drive == $past(core_out)) else $error("pin path");
    reset_instr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(rst_n) |-> active_instr == bst_pkg::IR_IDCODE && !test_mode) else $error("reset instruction");
endmodule
bind bst_test_port bst_test_port_monitor u_bst_test_port_monitor (.core_clk(core_clk), .rst_n(rst_n),
    .tck(tck), .tms(tms), .tdo_oe_n(tdo_oe_n), .core_out(core_out), .pin_drive(pin_drive),
    .test_mode(test_mode), .active_instr(active_instr));

/* tb/bst_tester.sv */
// partner model: boundary-scan tester on tck, tms and tdi
`timescale 1ns/1ns
module bst_tester (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    // ========
    // tck only runs inside frames; tdo taken at the rising edge
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #3 o = tdo;
        tck = 1'b1;
        #3 tck = 1'b0;
    endtask
    task automatic reset5();
        logic o;
        repeat (5) step(1'b1, 1'b0, o);
        step(1'b0, 1'b1, o);
    endtask
    task automatic scan(input logic ir, input int n, input logic [bst_pkg::BC_W-1:0] din,
        output logic [bst_pkg::BC_W-1:0] dout);
        logic o;
        dout = '0;
        step(1'b1, 1'b0, o);
        if (ir) step(1'b1, 1'b1, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, ~din[n-1], o);
        step(1'b0, din[n-1], o);
    endtask
endmodule

/* tb/test_bst_test_port.sv */
// testbench: boundary-scan test port scenarios
`timescale 1ns/1ns
module test_bst_test_port;
    localparam logic [97:0] PAT = {34'h2A5A5A5A5, 64'hF0E1D2C3B4A59687};
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic tck, tms, tdi, tdo, tdo_oe_n, test_mode;
    logic [2:0] active_instr;
    logic [bst_pkg::BC_W-1:0] pin_capture = '0;
    logic [bst_pkg::BC_W-1:0] core_out = '0;
    logic [bst_pkg::BC_W-1:0] pin_drive, got;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    bst_tester u_bst_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    bst_test_port u_bst_test_port (.core_clk(core_clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pin_capture(pin_capture), .core_out(core_out),
        .pin_drive(pin_drive), .test_mode(test_mode), .active_instr(active_instr));
    // ========
    // clock, watchdog, checks
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic chk(input string what, input logic [97:0] exp, input logic [97:0] act);
        samples_checked++;
        if (act !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, act);
        end
    endtask
    task automatic report_and_stop();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic t_idcode();
        u_bst_tester.scan(1'b0, 32, '0, got);
        chk("idcode", {bst_pkg::ID_REV, bst_pkg::ID_PART, bst_pkg::ID_PRODUCER, 1'b1}, got);
    endtask
    task automatic t_bypass();
        logic [2:0] codes [5] = '{3'h7, 3'h1, 3'h2, 3'h3, 3'h5};
        foreach (codes[k]) begin
            u_bst_tester.scan(1'b1, 3, codes[k], got);
            chk("ir capture", bst_pkg::IR_CAPTURE, got);
            u_bst_tester.scan(1'b0, 8, 98'hB5, got);
            chk("bypass", 98'h6A, got);
        end
    endtask
    task automatic t_sample();
        u_bst_tester.scan(1'b1, 3, bst_pkg::IR_SAMPLE, got);
        @(posedge core_clk);
        pin_capture <= ~PAT;
        core_out <= {PAT[48:0], PAT[97:49]};
        repeat (5) @(posedge core_clk);
        u_bst_tester.scan(1'b0, 98, PAT, got);
        chk("sample capture", ~PAT, got);
        repeat (5) @(posedge core_clk);
        chk("normal path", {PAT[48:0], PAT[97:49]}, pin_drive);
    endtask
    task automatic t_extest();
        u_bst_tester.scan(1'b1, 3, bst_pkg::IR_EXTEST, got);
        repeat (5) @(posedge core_clk);
        chk("preload drive", PAT, pin_drive);
        chk("test mode", 1'b1, test_mode);
        u_bst_tester.scan(1'b0, 98, ~PAT, got);
        chk("extest capture", ~PAT, got);
        repeat (5) @(posedge core_clk);
        chk("extest drive", ~PAT, pin_drive);
    endtask
    task automatic t_tms_reset();
        u_bst_tester.reset5();
        repeat (5) @(posedge core_clk);
        chk("reset instr", bst_pkg::IR_IDCODE, active_instr);
        chk("reset drive", {PAT[48:0], PAT[97:49]}, pin_drive);
        t_idcode();
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk("power-up instr", bst_pkg::IR_IDCODE, active_instr);
        u_bst_tester.reset5();
        t_idcode();
        t_bypass();
        t_sample();
        t_extest();
        t_tms_reset();
        report_and_stop();
    end
endmodule
